// >>> cscr_core_regs.sv
// cscr_core_regs: accumulator, second operand, stack pointer, data pointer
// and status word; assumes the execution datapath and the special register
// port share clk
// Notes on behaviour
// - the accumulator is an 8-bit read/write register at E0H that resets to zero and takes results.
// - the second operand register is read/write at F0H, resets to zero and holds multiply and divide results.
// - a push first increments the stack pointer and then writes the byte at the new pointer.
// - the stack pointer at 81H resets to 07H so the first pushed byte lands at 08H.
// - the low byte at 82H and high byte at 83H form one 16-bit pointer with the high byte on top.
// - after add or subtract the carry shows a carry out of or a borrow into the top bit.
// - after multiply or divide the carry is cleared.
// - a compare-and-jump sets the carry when the first unsigned operand is below the second.
// - decimal adjust sets the carry when the packed decimal sum passed two digits.
// - the auxiliary carry shows a carry out of or a borrow into bit 3.
// - the status word at D0H resets to zero, bits 7 to 1 are read/write and bit 0 is read-only.
// - the two bank bits select one of four eight-byte banks starting at 00H, 08H, 10H or 18H.
// - status bit 5 is a user flag with no hardware effect.
`timescale 1ns/1ps
module cscr_core_regs #(
  parameter int DW = 8
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                ce,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  output logic      [7:0]          sfr_rdata_q,
  output logic                     sfr_hit_q,
  input  wire cscr_pkg::cscr_op_t  op_in,
  output cscr_pkg::cscr_stk_t      stk_q,
  output logic      [7:0]          acc_q,
  output logic      [7:0]          b_q,
  output logic      [7:0]          sp_q,
  output logic      [7:0]          psw_q,
  output logic      [15:0]         data_pointer_16bit,
  output logic      [7:0]          bank_base
);
  import cscr_pkg::*;

  if (DW != 8) begin : g_dw_chk
    $error("cscr_core_regs supports only 8-bit data");
  end

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == ADDR_SP) || (a == ADDR_DPL) || (a == ADDR_DPH) ||
              (a == ADDR_PSW) || (a == ADDR_ACC) || (a == ADDR_B);
  endfunction

  logic [7:0] dpl_q;
  logic [7:0] dph_q;
  logic [7:0] acc_d;
  logic [7:0] b_d;
  logic [7:0] sp_d;
  logic [7:0] dpl_d;
  logic [7:0] dph_d;
  logic [7:0] psw_d;
  logic [7:0] rdata_d;
  logic       hit_d;
  cscr_stk_t  stk_d;
  cscr_res_t  res;
  logic       is_alu;

  cscr_alu u_alu (
    .acc (acc_q),
    .bop (b_q),
    .program_status_word (psw_q),
    .op  (op_in),
    .res (res)
  );

  // pointer and bank views straight from the registers
  assign data_pointer_16bit = {dph_q, dpl_q};
  assign bank_base = {3'b000, psw_q[PSW_RS1], psw_q[PSW_RS0], 3'b000};

  assign is_alu = op_in.vld && (op_in.kind != CSCR_PUSH) &&
                  (op_in.kind != CSCR_POP) && (op_in.kind != CSCR_NOP);

  // next state: core operation first, a register-port write overrides it
  always_comb begin
    acc_d = acc_q;
    b_d   = b_q;
    sp_d  = sp_q;
    dpl_d = dpl_q;
    dph_d = dph_q;
    psw_d = psw_q;
    stk_d = '0;
    if (is_alu) begin
      if (res.wr_a) begin
        acc_d = res.a;
      end
      if (res.wr_b) begin
        b_d = res.b;
      end
      if (res.wr_cy) begin
        psw_d[PSW_CY] = res.cy;
      end
      if (res.wr_ac) begin
        psw_d[PSW_AC] = res.ac;
      end
      if (res.wr_ov) begin
        psw_d[PSW_OV] = res.ov;
      end
    end else if (op_in.vld && op_in.kind == CSCR_PUSH) begin
      sp_d       = sp_q + 8'h01;
      stk_d.we   = 1'b1;
      stk_d.addr = sp_q + 8'h01;
      stk_d.data = op_in.opnd_x;
    end else if (op_in.vld && op_in.kind == CSCR_POP) begin
      stk_d.addr = sp_q;
      sp_d       = sp_q - 8'h01;
    end
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_ACC: begin
          acc_d = sfr_wdata;
        end
        ADDR_B: begin
          b_d = sfr_wdata;
        end
        ADDR_SP: begin
          sp_d = sfr_wdata;
        end
        ADDR_DPL: begin
          dpl_d = sfr_wdata;
        end
        ADDR_DPH: begin
          dph_d = sfr_wdata;
        end
        ADDR_PSW: begin
          psw_d[7:1] = sfr_wdata[7:1];
        end
        default: begin
          acc_d = acc_d;
        end
      endcase
    end
    psw_d[PSW_P] = ^acc_d;
  end

  // read path: one cycle after the strobe, unmapped reads give zero
  always_comb begin
    rdata_d = 8'h00;
    hit_d   = sfr_rd && reg_hit(sfr_addr);
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_ACC: begin
          rdata_d = acc_q;
        end
        ADDR_B: begin
          rdata_d = b_q;
        end
        ADDR_SP: begin
          rdata_d = sp_q;
        end
        ADDR_DPL: begin
          rdata_d = dpl_q;
        end
        ADDR_DPH: begin
          rdata_d = dph_q;
        end
        ADDR_PSW: begin
          rdata_d = psw_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_q       <= RST_ACC;
      b_q         <= RST_B;
      sp_q        <= RST_SP;
      dpl_q       <= RST_DPL;
      dph_q       <= RST_DPH;
      psw_q       <= RST_PSW;
      stk_q       <= '0;
      sfr_rdata_q <= 8'h00;
      sfr_hit_q   <= 1'b0;
    end else if (ce) begin
      acc_q       <= acc_d;
      b_q         <= b_d;
      sp_q        <= sp_d;
      dpl_q       <= dpl_d;
      dph_q       <= dph_d;
      psw_q       <= psw_d;
      stk_q       <= stk_d;
      sfr_rdata_q <= rdata_d;
      sfr_hit_q   <= hit_d;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic       go;
  logic [8:0] add_chk;
  logic       lt_chk;
  logic       nib_chk;
  logic       sub_chk;
  logic       ovf_chk;

  assign go      = ce && op_in.vld && !sfr_wr;
  assign add_chk = {1'b0, acc_q} + {1'b0, op_in.opnd_y};
  assign lt_chk  = op_in.opnd_x < op_in.opnd_y;
  assign nib_chk = ({1'b0, acc_q[3:0]} + {1'b0, op_in.opnd_y[3:0]}) > 5'h0F;
  assign sub_chk = acc_q < op_in.opnd_y;
  assign ovf_chk = add_chk[8] ^ (({1'b0, acc_q[6:0]} + {1'b0, op_in.opnd_y[6:0]}) > 8'h7F);

  sequence s_push_req;
    go && op_in.kind == CSCR_PUSH;
  endsequence

  sequence s_push_done(logic [7:0] old_sp);
    stk_q.we && stk_q.addr == old_sp + 8'h01 && sp_q == stk_q.addr;
  endsequence

  a_acc_read: assert property (ce && sfr_rd && sfr_addr == ADDR_ACC |=>
      sfr_hit_q && sfr_rdata_q == $past(acc_q))
    else $error("accumulator read returned wrong data");

  a_b_after_mul: assert property (go && op_in.kind == CSCR_MUL |=>
      {b_q, acc_q} == $past(acc_q) * $past(b_q))
    else $error("multiply product not in the operand pair");

  a_push_order: assert property (s_push_req |=> s_push_done($past(sp_q)))
    else $error("push did not pre-increment the stack pointer");

  a_sp_reset: assert property ($rose(rstn) |-> sp_q == RST_SP && !stk_q.we)
    else $error("stack pointer reset value wrong");

  a_data_pointer_16bit_pair: assert property (ce && sfr_wr && sfr_addr == ADDR_DPH |=>
      data_pointer_16bit[15:8] == $past(sfr_wdata) &&
      data_pointer_16bit[7:0] == $past(data_pointer_16bit[7:0]))
    else $error("data pointer high byte not on top");

  a_add_carry: assert property (go && op_in.kind == CSCR_ADD && !op_in.cin_en |=>
      {psw_q[PSW_CY], acc_q} == $past(add_chk))
    else $error("add carry or sum wrong");

  a_muldiv_cy: assert property (go && (op_in.kind == CSCR_MUL || op_in.kind == CSCR_DIV) |=>
      !psw_q[PSW_CY])
    else $error("carry not cleared after multiply or divide");

  a_compare_jump_not_equal_cy: assert property (go && op_in.kind == CSCR_COMPARE_JUMP_NOT_EQUAL |=>
      psw_q[PSW_CY] == $past(lt_chk) && acc_q == $past(acc_q))
    else $error("compare carry wrong");

  a_da_carry: assert property (go && op_in.kind == CSCR_DA && psw_q[PSW_CY] |=>
      psw_q[PSW_CY])
    else $error("decimal adjust dropped the carry");

  a_aux_carry: assert property (go && op_in.kind == CSCR_ADD && !op_in.cin_en |=>
      psw_q[PSW_AC] == $past(nib_chk))
    else $error("auxiliary carry wrong");

  a_psw_ro: assert property (ce && sfr_wr && sfr_addr == ADDR_PSW |=>
      psw_q[7:1] == $past(sfr_wdata[7:1]) && psw_q[PSW_P] == ^acc_q)
    else $error("status word write wrong");

  a_bank_map: assert property (bank_base == ({6'h00, psw_q[PSW_RS1], psw_q[PSW_RS0]} << 3))
    else $error("bank base wrong");

  a_user_flag: assert property (!(ce && sfr_wr && sfr_addr == ADDR_PSW) |=>
      psw_q[PSW_F0] == $past(psw_q[PSW_F0]))
    else $error("user flag changed by hardware");

  a_parity: assert property (psw_q[PSW_P] == ^acc_q)
    else $error("parity does not match accumulator");

  a_div_zero: assert property (go && op_in.kind == CSCR_DIV && b_q == 8'h00 |=>
      psw_q[PSW_OV] && acc_q == $past(acc_q) && b_q == 8'h00)
    else $error("divide by zero not flagged");

  a_adjust_high: assert property (go && op_in.kind == CSCR_DA && acc_q[7:4] > NIB_MAX |=>
      psw_q[PSW_CY])
    else $error("decimal adjust carry not set above two digits");

  a_sub_borrow: assert property (go && op_in.kind == CSCR_SUB && !op_in.cin_en |=>
      psw_q[PSW_CY] == $past(sub_chk))
    else $error("subtract borrow wrong");

  a_add_overflow: assert property (go && op_in.kind == CSCR_ADD && !op_in.cin_en |=>
      psw_q[PSW_OV] == $past(ovf_chk))
    else $error("add overflow wrong");

  a_reset_values: assert property ($rose(rstn) |-> acc_q == RST_ACC && b_q == RST_B &&
      psw_q == RST_PSW && data_pointer_16bit == {RST_DPH, RST_DPL})
    else $error("register reset values wrong");

  a_ce_freeze: assert property (!ce |=> acc_q == $past(acc_q) && b_q == $past(b_q) &&
      sp_q == $past(sp_q) && psw_q == $past(psw_q))
    else $error("state changed while clock enable low");

  a_unmapped_read: assert property (ce && sfr_rd && !reg_hit(sfr_addr) |=>
      !sfr_hit_q && sfr_rdata_q == 8'h00)
    else $error("unmapped read answered");

  a_second_read: assert property (ce && sfr_rd && sfr_addr == ADDR_B |=>
      sfr_hit_q && sfr_rdata_q == $past(b_q))
    else $error("second operand read returned wrong data");

endmodule

// >>> cscr_pkg.sv
// cscr_pkg: addresses, reset values, flag positions and carriers of the
// core special registers; assumes an 8-bit special register port
package cscr_pkg;

  localparam logic [7:0] ADDR_SP  = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_B   = 8'hF0;

  localparam logic [7:0] RST_SP  = 8'h07;
  localparam logic [7:0] RST_DPL = 8'h00;
  localparam logic [7:0] RST_DPH = 8'h00;
  localparam logic [7:0] RST_PSW = 8'h00;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_B   = 8'h00;

  localparam int unsigned PSW_CY  = 7;
  localparam int unsigned PSW_AC  = 6;
  localparam int unsigned PSW_F0  = 5;
  localparam int unsigned PSW_RS1 = 4;
  localparam int unsigned PSW_RS0 = 3;
  localparam int unsigned PSW_OV  = 2;
  localparam int unsigned PSW_F1  = 1;
  localparam int unsigned PSW_P   = 0;

  localparam logic [3:0] NIB_MAX = 4'h9;
  localparam logic [8:0] DA_LO   = 9'h006;
  localparam logic [8:0] DA_HI   = 9'h060;

  typedef enum logic [3:0] {
    CSCR_NOP  = 4'b0000,
    CSCR_ADD  = 4'b0001,
    CSCR_SUB  = 4'b0010,
    CSCR_MUL  = 4'b0011,
    CSCR_DIV  = 4'b0100,
    CSCR_COMPARE_JUMP_NOT_EQUAL = 4'b0101,
    CSCR_DA   = 4'b0110,
    CSCR_PUSH = 4'b0111,
    CSCR_POP  = 4'b1000
  } cscr_kind_t;

  typedef struct packed {
    logic       vld;
    cscr_kind_t kind;
    logic [7:0] opnd_x;
    logic [7:0] opnd_y;
    logic       cin_en;
  } cscr_op_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } cscr_stk_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic       cy;
    logic       ac;
    logic       ov;
    logic       wr_a;
    logic       wr_b;
    logic       wr_cy;
    logic       wr_ac;
    logic       wr_ov;
  } cscr_res_t;

endpackage

// >>> cscr_alu.sv
// cscr_alu: combinational results and flags of the arithmetic operations
// assumes operands come from the register file on the same clock
`timescale 1ns/1ps
module cscr_alu (
  input  wire logic [7:0]         acc,
  input  wire logic [7:0]         bop,
  input  wire logic [7:0]         program_status_word,
  input  wire cscr_pkg::cscr_op_t op,
  output cscr_pkg::cscr_res_t     res
);
  import cscr_pkg::*;

  function automatic logic nib_gt9(input logic [3:0] n);
    nib_gt9 = (n > NIB_MAX);
  endfunction

  logic       cin;
  logic [8:0] sum9;
  logic [8:0] dif9;
  logic [4:0] slo;
  logic [4:0] dlo;
  logic [15:0] prod;
  logic [8:0] dat;

  assign cin  = op.cin_en & program_status_word[PSW_CY];
  assign sum9 = {1'b0, acc} + {1'b0, op.opnd_y} + {8'h00, cin};
  assign dif9 = {1'b0, acc} - {1'b0, op.opnd_y} - {8'h00, cin};
  assign slo  = {1'b0, acc[3:0]} + {1'b0, op.opnd_y[3:0]} + {4'h0, cin};
  assign dlo  = {1'b0, acc[3:0]} - {1'b0, op.opnd_y[3:0]} - {4'h0, cin};
  assign prod = acc * bop;

  always_comb begin
    res = '0;
    dat = {1'b0, acc};
    case (op.kind)
      CSCR_ADD: begin
        res.a  = sum9[7:0];
        res.cy = sum9[8];
        res.ac = slo[4];
        res.ov = (acc[7] == op.opnd_y[7]) && (sum9[7] != acc[7]);
        {res.wr_a, res.wr_cy, res.wr_ac, res.wr_ov} = 4'hF;
      end
      CSCR_SUB: begin
        res.a  = dif9[7:0];
        res.cy = dif9[8];
        res.ac = dlo[4];
        res.ov = (acc[7] != op.opnd_y[7]) && (dif9[7] != acc[7]);
        {res.wr_a, res.wr_cy, res.wr_ac, res.wr_ov} = 4'hF;
      end
      CSCR_MUL: begin
        res.a  = prod[7:0];
        res.b  = prod[15:8];
        res.cy = 1'b0;
        res.ov = |prod[15:8];
        {res.wr_a, res.wr_b, res.wr_cy, res.wr_ov} = 4'hF;
      end
      CSCR_DIV: begin
        res.cy    = 1'b0;
        res.ov    = (bop == 8'h00);
        res.wr_cy = 1'b1;
        res.wr_ov = 1'b1;
        if (bop != 8'h00) begin
          res.a    = acc / bop;
          res.b    = acc % bop;
          res.wr_a = 1'b1;
          res.wr_b = 1'b1;
        end
      end
      CSCR_COMPARE_JUMP_NOT_EQUAL: begin
        res.cy    = (op.opnd_x < op.opnd_y);
        res.wr_cy = 1'b1;
      end
      CSCR_DA: begin
        if (nib_gt9(dat[3:0]) || program_status_word[PSW_AC]) begin
          dat = dat + DA_LO;
        end
        if (nib_gt9(dat[7:4]) || dat[8] || program_status_word[PSW_CY]) begin
          dat = dat + DA_HI;
        end
        res.a     = dat[7:0];
        res.cy    = dat[8] | program_status_word[PSW_CY];
        res.wr_a  = 1'b1;
        res.wr_cy = 1'b1;
      end
      default: begin
        res = '0;
      end
    endcase
  end
endmodule

// >>> cscr_core_model.sv
// cscr_core_model: stands in for the execution datapath that feeds op_in
// assumes the bench calls issue and that clk is the core clock
`timescale 1ns/1ps
module cscr_core_model (
  input  wire logic          clk,
  output cscr_pkg::cscr_op_t op
);
  import cscr_pkg::*;

  initial op = '0;

  // one op per call, gap plus one idle cycles first, driven at the falling edge
  task automatic issue(input cscr_kind_t k, input logic [7:0] x, input logic [7:0] y, input logic c,
                       input int gap);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    op = '{vld: 1'b1, kind: k, opnd_x: x, opnd_y: y, cin_en: c};
    @(negedge clk);
    // released operands show the inverse, never the old value
    op = '{vld: 1'b0, kind: cscr_kind_t'(~k), opnd_x: ~x, opnd_y: ~y, cin_en: ~c};
  endtask
endmodule

// >>> tb.sv
// tb: register port and core op tests of cscr_core_regs
// assumes cscr_core_model drives op_in and the bench drives the register port
`timescale 1ns/1ps
module tb;
  import cscr_pkg::*;
  logic        clk;
  logic        rstn;
  logic        ce;
  logic        sfr_wr;
  logic        sfr_rd;
  logic        sfr_hit_q;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata_q;
  logic [7:0]  acc_q;
  logic [7:0]  b_q;
  logic [7:0]  sp_q;
  logic [7:0]  psw_q;
  logic [7:0]  bank_base;
  logic [15:0] data_pointer_16bit;
  cscr_op_t    op_in;
  cscr_stk_t   stk_q;
  int          n_fail;
  int          checks_done;
  int          cycles;
  logic [7:0]  addrs [6] = '{ADDR_SP, ADDR_DPL, ADDR_DPH, ADDR_PSW, ADDR_ACC, ADDR_B};
  logic [7:0]  rsts  [6] = '{RST_SP, RST_DPL, RST_DPH, RST_PSW, RST_ACC, RST_B};
  logic [7:0]  pats  [6] = '{8'h3C, 8'h34, 8'h12, 8'hFF, 8'h5B, 8'hA5};
  logic [7:0]  exps  [6] = '{8'h3C, 8'h34, 8'h12, 8'hFE, 8'h5B, 8'hA5};

  cscr_core_regs #(.DW(8)) dut (
    .clk(clk), .rstn(rstn), .ce(ce), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .sfr_hit_q(sfr_hit_q), .op_in(op_in),
    .stk_q(stk_q), .acc_q(acc_q), .b_q(b_q), .sp_q(sp_q), .psw_q(psw_q),
    .data_pointer_16bit(data_pointer_16bit), .bank_base(bank_base)
  );

  cscr_core_model core (
    .clk(clk),
    .op(op_in)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_wdata = ~d;
  endtask

  // exp is {hit, data}
  task automatic rd(input logic [7:0] a, input logic [8:0] exp);
    @(negedge clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk({sfr_hit_q, sfr_rdata_q}, exp);
  endtask

  // f is {carry, aux carry, overflow}; user flag bit 5 is held at 1
  task automatic alu(input cscr_kind_t k, input logic [7:0] x, input logic [7:0] y, input logic [7:0] ea,
                     input logic [7:0] eb, input logic [2:0] f);
    core.issue(k, x, y, 1'b0, 0);
    chk({acc_q, b_q, psw_q}, {ea, eb, f[2:1], 3'b100, f[0], 1'b0, ^ea});
  endtask

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    chk({sp_q, data_pointer_16bit}, {RST_SP, 16'h0000});
    chk({stk_q, bank_base, sfr_hit_q}, 26'h0);
    for (int i = 0; i < 6; i++) rd(addrs[i], {1'b1, rsts[i]});
    core.issue(CSCR_PUSH, 8'hAA, 8'h00, 1'b0, 0);
    chk({sp_q, stk_q}, {8'h08, 1'b1, 8'h08, 8'hAA});
    core.issue(CSCR_PUSH, 8'h55, 8'h00, 1'b0, 0);
    chk({sp_q, stk_q}, {8'h09, 1'b1, 8'h09, 8'h55});
    @(negedge clk);
    chk(stk_q.we, 1'b0);
    core.issue(CSCR_POP, 8'h00, 8'h00, 1'b0, 3);
    chk({sp_q, stk_q.we, stk_q.addr}, {8'h08, 1'b0, 8'h09});
    rd(8'h80, 9'h000);
    for (int i = 0; i < 6; i++) begin
      wr(addrs[i], pats[i]);
      rd(addrs[i], {1'b1, exps[i]});
    end
    chk({psw_q, data_pointer_16bit}, {8'hFF, 16'h1234});
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PSW, 8'(i << 3));
      chk(bank_base, 8'(i * 8));
    end
    wr(ADDR_PSW, 8'h20);
    wr(ADDR_ACC, 8'h7F);
    alu(CSCR_ADD, 8'h00, 8'h01, 8'h80, 8'hA5, 3'b011);
    alu(CSCR_SUB, 8'h00, 8'h01, 8'h7F, 8'hA5, 3'b011);
    alu(CSCR_ADD, 8'h00, 8'h80, 8'hFF, 8'hA5, 3'b000);
    wr(ADDR_ACC, 8'h80);
    alu(CSCR_ADD, 8'h00, 8'h80, 8'h00, 8'hA5, 3'b101);
    wr(ADDR_ACC, 8'h10);
    wr(ADDR_B, 8'h20);
    alu(CSCR_MUL, 8'h00, 8'h00, 8'h00, 8'h02, 3'b001);
    wr(ADDR_ACC, 8'h25);
    wr(ADDR_B, 8'h07);
    alu(CSCR_DIV, 8'h00, 8'h00, 8'h05, 8'h02, 3'b000);
    wr(ADDR_B, 8'h00);
    alu(CSCR_DIV, 8'h00, 8'h00, 8'h05, 8'h00, 3'b001);
    alu(CSCR_COMPARE_JUMP_NOT_EQUAL, 8'h03, 8'h05, 8'h05, 8'h00, 3'b101);
    alu(CSCR_COMPARE_JUMP_NOT_EQUAL, 8'h05, 8'h03, 8'h05, 8'h00, 3'b001);
    wr(ADDR_ACC, 8'h55);
    alu(CSCR_ADD, 8'h00, 8'h55, 8'hAA, 8'h00, 3'b001);
    core.issue(CSCR_DA, 8'h00, 8'h00, 1'b0, 0);
    chk({acc_q, psw_q[7]}, {8'h10, 1'b1});
    core.issue(CSCR_DA, 8'h00, 8'h00, 1'b0, 0);
    chk({acc_q, psw_q[7]}, {8'h70, 1'b1});
    rd(ADDR_ACC, 9'h170);
    ce = 1'b0;
    wr(ADDR_ACC, 8'h77);
    chk(acc_q, 8'h70);
    ce = 1'b1;
    give_verdict();
  end
endmodule
